// ---- common/fault_sup_pkg.sv ----
// Summary of operation
// - Start up once enable reaches turn-on level
// - Persistent low feedback forces output low
// - Low-output trip drives power-good low
// - Low-output protection armed only enable and soft-start
// - Persistent high feedback forces output low
// - High-output protection armed only enable and soft-start
// - Undervoltage enters standby, release needs hysteresis
// - Persistent timing resistor fault forces output low
// - Timing resistor monitor active whenever enable is high and supply up
// - Soft-start timeout enters off latch
// - Any protection trip latches off
// - Off latch clears only on enable low
// - Over-temperature holds output low
// - Cut switch conduction each overcurrent cycle
// - Persistent overcurrent forces output low
package fault_sup_pkg;
   // ----------------------------------------
   // Timing
   // ----------------------------------------
   localparam int CLK_PERIOD_NS = 40;
   localparam int QUAL_TIME_NS = 500000;
   localparam int SS_TIMEOUT_NS = 64000000;
   localparam int QUAL_CYCLES = (QUAL_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SS_TIMEOUT_CYCLES = (SS_TIMEOUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // ----------------------------------------
   // Register map
   // ----------------------------------------
   localparam int ADDR_W = 4;
   localparam int DATA_W = 32;
   localparam logic [3:0] CTRL_ADDR = 4'h0;
   localparam logic [3:0] STATUS_ADDR = 4'h4;
   localparam logic [3:0] IRQ_STATUS_ADDR = 4'h8;
   localparam logic [3:0] IRQ_MASK_ADDR = 4'hc;
   localparam int CTRL_FORCE_OFF_BIT = 0;
   localparam int STAT_PG_BIT = 8;
   localparam int STAT_ON_BIT = 9;
   localparam int STAT_LATCH_BIT = 10;
   localparam int STAT_STANDBY_BIT = 11;
   localparam int STAT_STATE_LSB = 12;
   localparam logic [5:0] IRQ_MASK_RESET = 6'h00;
   // ----------------------------------------
   // Fault indexes
   // ----------------------------------------
   localparam int N_PERSIST = 4;
   localparam int N_FAULT = 6;
   localparam int FLT_LOW = 0;
   localparam int FLT_HIGH = 1;
   localparam int FLT_RT = 2;
   localparam int FLT_OC = 3;
   localparam int FLT_SS_TO = 4;
   localparam int FLT_THERM = 5;

   typedef enum logic [1:0] {ST_IDLE, ST_SOFT, ST_RUN, ST_LATCH} state_type;

   // Comparator results from the analog side, all asynchronous
   typedef struct packed {
      logic enable_input_level;
      logic ss_arm_level;
      logic soft_start_done_threshold;
      logic fb_below_window;
      logic fb_above_window;
      logic vin_below_lockout;
      logic vin_above_release;
      logic timing_resistor_open_short;
      logic current_limit;
      logic thermal_shutdown;
   } pins_type;
endpackage

// ---- src/converter_fault_supervisor.sv ----
// Register access over Avalon-MM and the register addresses were decided locally.
`timescale 1ns/100ps
module converter_fault_supervisor #(
   parameter int QUAL_CYC = fault_sup_pkg::QUAL_CYCLES,
   parameter int SS_CYC = fault_sup_pkg::SS_TIMEOUT_CYCLES
) (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire fault_sup_pkg::pins_type pins,
   input wire logic [fault_sup_pkg::ADDR_W-1:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [fault_sup_pkg::DATA_W-1:0] writedata,
   output logic [fault_sup_pkg::DATA_W-1:0] readdata,
   output logic waitrequest,
   output logic converter_on,
   output logic cycle_cut,
   output logic power_good_output,
   output logic irq
);
   localparam int QW = $clog2(QUAL_CYC + 1);
   localparam int SW = $clog2(SS_CYC + 1);
   localparam int NP = fault_sup_pkg::N_PERSIST;
   localparam int NF = fault_sup_pkg::N_FAULT;
   localparam logic [QW-1:0] QLAST = QW'(QUAL_CYC - 1);
   localparam logic [SW-1:0] SLAST = SW'(SS_CYC - 1);

   typedef struct packed {
      fault_sup_pkg::pins_type s1;
      fault_sup_pkg::pins_type s2;
      fault_sup_pkg::state_type st;
      logic [NP-1:0][QW-1:0] pcnt;
      logic [SW-1:0] ss_cnt;
      logic [NF-1:0] cause;
      logic [NF-1:0] ist;
      logic [NF-1:0] imask;
      logic stby;
      logic force_off;
      logic pg;
      logic conv_on;
      logic cut;
      logic ack;
      logic [fault_sup_pkg::DATA_W-1:0] rdata;
   } regs_type;

   regs_type r;
   regs_type r_nxt;
   fault_sup_pkg::pins_type p;
   logic en;
   logic active;
   logic [NP-1:0] cond;
   logic [NF-1:0] ev;
   logic [NF-1:0] w1c;
   logic req;

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb begin
      r_nxt = r;
      // First stage feeds only the second
      r_nxt.s1 = pins;
      r_nxt.s2 = r.s1;
      p = r.s2;
      en = p.enable_input_level;
      active = (r.st == fault_sup_pkg::ST_SOFT) || (r.st == fault_sup_pkg::ST_RUN);
      req = read | write;
      w1c = '0;

      // Lockout level and release level come from separate comparators,
      // so the band between them keeps the present standby state
      if (p.vin_below_lockout) begin
         r_nxt.stby = 1'b1;
      end else if (p.vin_above_release) begin
         r_nxt.stby = 1'b0;
      end

      cond[fault_sup_pkg::FLT_LOW] = p.fb_below_window && p.ss_arm_level && active;
      cond[fault_sup_pkg::FLT_HIGH] = p.fb_above_window && p.ss_arm_level && active;
      cond[fault_sup_pkg::FLT_RT] = p.timing_resistor_open_short;
      cond[fault_sup_pkg::FLT_OC] = p.current_limit && active;

      ev = '0;
      for (int i = 0; i < NP; i++) begin
         if (!en || r.stby || !cond[i]) begin
            r_nxt.pcnt[i] = '0;
         end else if (r.pcnt[i] == QLAST) begin
            ev[i] = (r.st != fault_sup_pkg::ST_LATCH);
         end else begin
            r_nxt.pcnt[i] = r.pcnt[i] + 1'b1;
         end
      end

      // Timeout counts only during soft start
      if (r.st != fault_sup_pkg::ST_SOFT || !en || r.stby) begin
         r_nxt.ss_cnt = '0;
      end else if (r.ss_cnt == SLAST) begin
         ev[fault_sup_pkg::FLT_SS_TO] = !p.soft_start_done_threshold;
      end else begin
         r_nxt.ss_cnt = r.ss_cnt + 1'b1;
      end
      ev[fault_sup_pkg::FLT_THERM] = p.thermal_shutdown && active;

      case (r.st)
         fault_sup_pkg::ST_IDLE: begin
            if (|ev) begin
               r_nxt.st = fault_sup_pkg::ST_LATCH;
            end else if (en && !r.stby && !r.force_off) begin
               r_nxt.st = fault_sup_pkg::ST_SOFT;
            end
         end
         fault_sup_pkg::ST_SOFT: begin
            if (|ev) begin
               r_nxt.st = fault_sup_pkg::ST_LATCH;
            end else if (!en || r.stby || r.force_off) begin
               r_nxt.st = fault_sup_pkg::ST_IDLE;
            end else if (p.soft_start_done_threshold) begin
               r_nxt.st = fault_sup_pkg::ST_RUN;
            end
         end
         fault_sup_pkg::ST_RUN: begin
            if (|ev) begin
               r_nxt.st = fault_sup_pkg::ST_LATCH;
            end else if (!en || r.stby || r.force_off) begin
               r_nxt.st = fault_sup_pkg::ST_IDLE;
            end
         end
         fault_sup_pkg::ST_LATCH: begin
            // Standby alone does not release; only enable low does
            if (!en) begin
               r_nxt.st = fault_sup_pkg::ST_IDLE;
            end
         end
         default: begin
            r_nxt.st = fault_sup_pkg::ST_IDLE;
         end
      endcase

      if (r.st == fault_sup_pkg::ST_LATCH && !en) begin
         r_nxt.cause = '0;
      end else begin
         r_nxt.cause = r.cause | ev;
      end

      r_nxt.conv_on = ((r_nxt.st == fault_sup_pkg::ST_SOFT) || (r_nxt.st == fault_sup_pkg::ST_RUN))
                      && !p.thermal_shutdown;
      r_nxt.pg = (r_nxt.st == fault_sup_pkg::ST_RUN);
      // Per-cycle cut follows the comparator; latency is the two sync stages plus the cut register
      r_nxt.cut = p.current_limit && r.conv_on;

      // ----------------------------------------
      // Avalon slave, one wait state per access
      // ----------------------------------------
      if (req && !r.ack) begin
         r_nxt.ack = 1'b1;
         r_nxt.rdata = '0;
         if (address == fault_sup_pkg::CTRL_ADDR) begin
            r_nxt.rdata[fault_sup_pkg::CTRL_FORCE_OFF_BIT] = r.force_off;
         end else if (address == fault_sup_pkg::STATUS_ADDR) begin
            r_nxt.rdata[NF-1:0] = r.cause;
            r_nxt.rdata[fault_sup_pkg::STAT_PG_BIT] = r.pg;
            r_nxt.rdata[fault_sup_pkg::STAT_ON_BIT] = r.conv_on;
            r_nxt.rdata[fault_sup_pkg::STAT_LATCH_BIT] = (r.st == fault_sup_pkg::ST_LATCH);
            r_nxt.rdata[fault_sup_pkg::STAT_STANDBY_BIT] = r.stby;
            r_nxt.rdata[fault_sup_pkg::STAT_STATE_LSB +: 2] = r.st;
         end else if (address == fault_sup_pkg::IRQ_STATUS_ADDR) begin
            r_nxt.rdata[NF-1:0] = r.ist;
         end else if (address == fault_sup_pkg::IRQ_MASK_ADDR) begin
            r_nxt.rdata[NF-1:0] = r.imask;
         end
      end else begin
         r_nxt.ack = 1'b0;
      end

      if (write && r.ack) begin
         if (address == fault_sup_pkg::CTRL_ADDR) begin
            r_nxt.force_off = writedata[fault_sup_pkg::CTRL_FORCE_OFF_BIT];
         end else if (address == fault_sup_pkg::IRQ_STATUS_ADDR) begin
            w1c = writedata[NF-1:0];
         end else if (address == fault_sup_pkg::IRQ_MASK_ADDR) begin
            r_nxt.imask = writedata[NF-1:0];
         end
      end
      // A new event beats a clear in the same cycle
      r_nxt.ist = (r.ist & ~w1c) | ev;
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         r <= '0;
         r.st <= fault_sup_pkg::ST_IDLE;
         r.stby <= 1'b1;
         r.imask <= fault_sup_pkg::IRQ_MASK_RESET;
      end else begin
         r <= r_nxt;
      end
   end

   assign readdata = r.rdata;
   assign waitrequest = req && !r.ack;
   assign converter_on = r.conv_on;
   assign cycle_cut = r.cut;
   assign power_good_output = r.pg;
   assign irq = |(r.ist & r.imask);

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!rst_n);

   start_on_enable_a: assert property (
      (r.st == fault_sup_pkg::ST_IDLE) && r.s2.enable_input_level && !r.stby && !r.force_off && (ev == '0)
      |=> (r.st == fault_sup_pkg::ST_SOFT) ##1 converter_on || r.s2.thermal_shutdown || r.st != fault_sup_pkg::ST_SOFT)
      else $error("enable did not start soft start");
   low_trip_latch_a: assert property (
      ev[fault_sup_pkg::FLT_LOW] |=> (r.st == fault_sup_pkg::ST_LATCH) ##1 !converter_on)
      else $error("low feedback did not latch off");
   pg_drop_a: assert property (
      ev[fault_sup_pkg::FLT_LOW] |=> ##1 !power_good_output)
      else $error("power good stayed high after low trip");
   low_disarm_a: assert property (
      !r.s2.ss_arm_level || !r.s2.enable_input_level |=> r.pcnt[fault_sup_pkg::FLT_LOW] == '0)
      else $error("low protection counted while disarmed");
   high_disarm_a: assert property (
      !r.s2.ss_arm_level || !r.s2.enable_input_level |=> r.pcnt[fault_sup_pkg::FLT_HIGH] == '0)
      else $error("high protection counted while disarmed");
   standby_off_a: assert property (
      r.s2.vin_below_lockout |=> r.stby ##1 !converter_on)
      else $error("undervoltage did not enter standby");
   persist_step_a: assert property (
      r.s2.timing_resistor_open_short && $past(r.s2.timing_resistor_open_short) && r.stby == 1'b0
      && r.s2.enable_input_level && r.pcnt[fault_sup_pkg::FLT_RT] != QLAST && !$past(r.stby)
      |=> r.pcnt[fault_sup_pkg::FLT_RT] == $past(r.pcnt[fault_sup_pkg::FLT_RT]) + 1'b1)
      else $error("persistence counter did not advance");
   ss_timeout_a: assert property (
      (r.st == fault_sup_pkg::ST_SOFT) && r.ss_cnt == SLAST && !r.s2.soft_start_done_threshold
      && r.s2.enable_input_level && !r.stby
      |=> r.st == fault_sup_pkg::ST_LATCH)
      else $error("soft start timeout missed");
   latch_hold_a: assert property (
      (r.st == fault_sup_pkg::ST_LATCH) && r.s2.enable_input_level |=> (r.st == fault_sup_pkg::ST_LATCH) && !converter_on)
      else $error("off latch released while enabled");
   latch_release_a: assert property (
      (r.st == fault_sup_pkg::ST_LATCH) && !r.s2.enable_input_level |=> (r.st == fault_sup_pkg::ST_IDLE) && r.cause == '0)
      else $error("off latch not released by enable low");
   thermal_off_a: assert property (
      r.s2.thermal_shutdown |=> !converter_on)
      else $error("output on during over temperature");
   cycle_cut_a: assert property (
      r.s2.current_limit && converter_on |=> cycle_cut)
      else $error("overcurrent did not cut the cycle");
   clean_restart_a: assert property (
      !r.s2.enable_input_level || r.stby |=> r.pcnt == '0 && r.ss_cnt == '0)
      else $error("counters not cleared on enable low or standby");

   // ----------------------------------------
   // Register bus checks
   // ----------------------------------------
   // One wait state on every access keeps the read path registered
   wait_first_a: assert property (
      (read || write) && !r.ack
      |-> waitrequest)
      else $error("first bus cycle not held off");
   one_wait_a: assert property (
      (read || write) && !r.ack
      |=> r.ack)
      else $error("bus access not answered after one wait");
   ack_drop_a: assert property (
      r.ack
      |=> !r.ack)
      else $error("bus answer stood longer than one cycle");
   rdata_hold_a: assert property (
      r.ack
      |=> $stable(readdata))
      else $error("read data changed while answered");
   ctrl_write_a: assert property (
      write && r.ack && (address == fault_sup_pkg::CTRL_ADDR)
      |=> r.force_off == $past(writedata[fault_sup_pkg::CTRL_FORCE_OFF_BIT]))
      else $error("control write lost");
   mask_write_a: assert property (
      write && r.ack && (address == fault_sup_pkg::IRQ_MASK_ADDR)
      |=> r.imask == $past(writedata[NF-1:0]))
      else $error("mask write lost");
   irq_clear_a: assert property (
      write && r.ack && (address == fault_sup_pkg::IRQ_STATUS_ADDR) && (ev == '0)
      |=> (r.ist & $past(writedata[NF-1:0])) == '0)
      else $error("interrupt status not cleared by write one");
   irq_set_a: assert property (
      ev != '0
      |=> (r.ist & $past(ev)) == $past(ev))
      else $error("event did not set interrupt status");

   // ----------------------------------------
   // State checks
   // ----------------------------------------
   cause_keep_a: assert property (
      r.st != fault_sup_pkg::ST_LATCH
      |=> (r.cause & $past(r.cause)) == $past(r.cause))
      else $error("latched cause lost");
   idle_stay_a: assert property (
      (r.st == fault_sup_pkg::ST_IDLE) && !r.s2.enable_input_level
      |=> r.st == fault_sup_pkg::ST_IDLE)
      else $error("left idle without enable");
   soft_done_a: assert property (
      (r.st == fault_sup_pkg::ST_SOFT) && (ev == '0) && r.s2.enable_input_level && !r.stby && !r.force_off
      && r.s2.soft_start_done_threshold |=> r.st == fault_sup_pkg::ST_RUN)
      else $error("soft start did not finish");
   force_idle_a: assert property (
      r.force_off && (r.st == fault_sup_pkg::ST_RUN) && (ev == '0)
      |=> r.st == fault_sup_pkg::ST_IDLE)
      else $error("force off ignored");
   stby_hold_a: assert property (
      r.stby && !r.s2.vin_above_release
      |=> r.stby)
      else $error("standby released inside hysteresis");
   stby_release_a: assert property (
      r.s2.vin_above_release && !r.s2.vin_below_lockout
      |=> !r.stby)
      else $error("standby not released above hysteresis");
   stby_no_start_a: assert property (
      r.stby && (r.st == fault_sup_pkg::ST_IDLE)
      |=> r.st != fault_sup_pkg::ST_SOFT)
      else $error("started during standby");
   latch_outputs_a: assert property (
      r.st == fault_sup_pkg::ST_LATCH
      |-> !power_good_output && !converter_on)
      else $error("outputs active in off latch");

   // ----------------------------------------
   // Counter checks
   // ----------------------------------------
   ss_count_a: assert property (
      (r.st == fault_sup_pkg::ST_SOFT) && r.s2.enable_input_level && !r.stby && r.ss_cnt != SLAST
      |=> r.ss_cnt == $past(r.ss_cnt) + 1'b1)
      else $error("soft start timer did not advance");
   ss_clear_a: assert property (
      r.st != fault_sup_pkg::ST_SOFT
      |=> r.ss_cnt == '0)
      else $error("soft start timer kept outside soft start");
   rt_restart_a: assert property (
      !r.s2.timing_resistor_open_short
      |=> r.pcnt[fault_sup_pkg::FLT_RT] == '0)
      else $error("resistor counter not restarted");
   oc_idle_a: assert property (
      (r.st == fault_sup_pkg::ST_IDLE) || (r.st == fault_sup_pkg::ST_LATCH)
      |=> r.pcnt[fault_sup_pkg::FLT_OC] == '0)
      else $error("overcurrent counted while off");
   low_idle_a: assert property (
      r.st == fault_sup_pkg::ST_IDLE
      |=> r.pcnt[fault_sup_pkg::FLT_LOW] == '0)
      else $error("low protection counted in idle");
   high_idle_a: assert property (
      r.st == fault_sup_pkg::ST_IDLE
      |=> r.pcnt[fault_sup_pkg::FLT_HIGH] == '0)
      else $error("high protection counted in idle");

   // ----------------------------------------
   // Trip and cycle cut checks
   // ----------------------------------------
   // Every trip must land in the latch, not in idle, or a restart would follow
   high_trip_a: assert property (
      ev[fault_sup_pkg::FLT_HIGH]
      |=> (r.st == fault_sup_pkg::ST_LATCH) ##1 !converter_on)
      else $error("high feedback did not latch off");
   rt_trip_a: assert property (
      ev[fault_sup_pkg::FLT_RT]
      |=> r.st == fault_sup_pkg::ST_LATCH)
      else $error("resistor fault did not latch off");
   oc_trip_a: assert property (
      ev[fault_sup_pkg::FLT_OC]
      |=> r.st == fault_sup_pkg::ST_LATCH)
      else $error("overcurrent did not latch off");
   therm_trip_a: assert property (
      ev[fault_sup_pkg::FLT_THERM]
      |=> r.st == fault_sup_pkg::ST_LATCH)
      else $error("over temperature did not latch off");
   cut_off_a: assert property (
      !converter_on
      |=> !cycle_cut)
      else $error("cycle cut while converter off");
   no_cut_a: assert property (
      !r.s2.current_limit
      |=> !cycle_cut)
      else $error("cycle cut without overcurrent");
endmodule // converter_fault_supervisor

// ---- verification/sys_ctrl_model.sv ----
`timescale 1ns/100ps
// ----------------------------------------
// System controller driving enable
// ----------------------------------------
module sys_ctrl_model (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic want_on,
   input wire logic slow,
   output logic enable_r
);
   logic [2:0] dly_r;
   // Slow mode lags the host decision by several cycles
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         enable_r <= 1'h0;
         dly_r <= 3'h0;
      end else if (enable_r != want_on) begin
         dly_r <= dly_r + 3'h1;
         if (!slow || dly_r == 3'h4) begin
            // Recovery is a full low pulse, never a glitch
            enable_r <= want_on;
            dly_r <= 3'h0;
         end
      end
   end
endmodule // sys_ctrl_model

// ---- verification/tb_top.sv ----
`timescale 1ns/100ps
module tb_top;
   localparam int QC = 8;
   localparam int SC = 40;
   localparam logic [3:0] STA = fault_sup_pkg::STATUS_ADDR;
   localparam logic [3:0] IST = fault_sup_pkg::IRQ_STATUS_ADDR;
   localparam logic [3:0] IMK = fault_sup_pkg::IRQ_MASK_ADDR;
   localparam logic [31:0] SM = 32'h3f3f;
   logic ref_clk = 1'h0;
   logic rst_n = 1'h0;
   fault_sup_pkg::pins_type pins_r = '0;
   fault_sup_pkg::pins_type pins_w;
   logic [3:0] address = 4'h0;
   logic read = 1'h0;
   logic write = 1'h0;
   logic [31:0] writedata = 32'h0;
   logic [31:0] readdata;
   logic waitrequest, converter_on, cycle_cut, power_good_output, irq, en_w;
   logic want_on = 1'h0;
   logic slow = 1'h0;
   logic [63:0] exp_q[$];
   logic [5:0] msk;
   int miscompares = 0;
   int checked = 0;
   int cycles = 0;
   int fl[5] = '{0, 1, 2, 3, 5};

   always #20 ref_clk = ~ref_clk;
   always_comb begin
      pins_w = pins_r;
      pins_w.enable_input_level = en_w;
   end
   sys_ctrl_model i_ctrl (.ref_clk(ref_clk), .rst_n(rst_n), .want_on(want_on), .slow(slow), .enable_r(en_w));
   converter_fault_supervisor #(.QUAL_CYC(QC), .SS_CYC(SC)) i_dut (.ref_clk(ref_clk), .rst_n(rst_n),
      .pins(pins_w), .address(address), .read(read), .write(write), .writedata(writedata),
      .readdata(readdata), .waitrequest(waitrequest), .converter_on(converter_on), .cycle_cut(cycle_cut),
      .power_good_output(power_good_output), .irq(irq));
   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task automatic end_of_test();
      if (miscompares == 0 && checked > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
      checked++;
      if (g !== e) begin
         miscompares++;
         $display("ERROR %s expected %h seen %h", what, e, g);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk);
   endtask
   // Reads note {mask, expected}; the monitor compares when data is taken
   task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d, input logic [31:0] m);
      @(posedge ref_clk);
      address <= a;
      writedata <= d;
      read <= !wr;
      write <= wr;
      if (!wr) exp_q.push_back({m, d});
      do @(posedge ref_clk); while (waitrequest !== 1'h0);
      read <= 1'h0;
      write <= 1'h0;
   endtask
   function automatic logic [31:0] st(input logic [5:0] c, input logic [3:0] f, input logic [1:0] s);
      return {18'h0, s, f, 2'h0, c};
   endfunction
   task automatic set_flt(input int i, input logic v);
      case (i)
         0: pins_r.fb_below_window <= v;
         1: pins_r.fb_above_window <= v;
         2: pins_r.timing_resistor_open_short <= v;
         3: pins_r.current_limit <= v;
         default: pins_r.thermal_shutdown <= v;
      endcase
   endtask
   task automatic start_up();
      pins_r.soft_start_done_threshold <= 1'h0;
      want_on <= 1'h1;
      tick(12);
      chk("converter_on", 32'h1, converter_on);
      pins_r.soft_start_done_threshold <= 1'h1;
      tick(8);
      chk("power_good_output", 32'h1, power_good_output);
   endtask
   task automatic recover();
      want_on <= 1'h0;
      tick(12);
      bus(1'h0, STA, 32'h0, SM);
   endtask
   // ----------------------------------------
   // Monitor and sequence
   // ----------------------------------------
   always @(posedge ref_clk) begin
      cycles <= cycles + 1;
      if (read && !waitrequest && exp_q.size() > 0) begin
         chk("readdata", exp_q[0][31:0], readdata & exp_q[0][63:32]);
         exp_q.delete(0);
      end
      if (cycles == 6000) begin
         miscompares++;
         end_of_test();
      end
   end
   initial begin
      void'($urandom(32'h99387dfb));
      tick(5);
      rst_n <= 1'h1;
      bus(1'h0, STA, 32'h800, SM);
      bus(1'h0, IMK, 32'h0, 32'h3f);
      bus(1'h0, 4'h6, 32'h0, 32'hffffffff);
      want_on <= 1'h1;
      tick(12);
      chk("converter_on", 32'h0, converter_on);
      pins_r.vin_above_release <= 1'h1;
      pins_r.ss_arm_level <= 1'h1;
      want_on <= 1'h0;
      tick(4);
      for (int k = 0; k < 5; k++) begin
         msk = 6'($urandom());
         bus(1'h1, IMK, {26'h0, msk}, 32'h0);
         bus(1'h0, IMK, {26'h0, msk}, 32'h3f);
         slow <= k[0];
         start_up();
         // Resistor monitor must not depend on soft-start arming
         pins_r.ss_arm_level <= (fl[k] != 2);
         set_flt(fl[k], 1'h1);
         tick(3 * QC);
         set_flt(fl[k], 1'h0);
         pins_r.ss_arm_level <= 1'h1;
         tick(4);
         chk("converter_on", 32'h0, converter_on);
         chk("power_good_output", 32'h0, power_good_output);
         chk("irq", {31'h0, msk[fl[k]]}, irq);
         bus(1'h0, STA, st(6'h1 << fl[k], 4'h4, 2'h3), SM);
         bus(1'h1, IST, 32'h3f, 32'h0);
         tick(1);
         chk("irq", 32'h0, irq);
         recover();
      end
      start_up();
      set_flt(3, 1'h1);
      tick(4);
      chk("cycle_cut", 32'h1, cycle_cut);
      set_flt(3, 1'h0);
      tick(1);
      set_flt(3, 1'h1);
      tick(4);
      set_flt(3, 1'h0);
      tick(10);
      chk("converter_on", 32'h1, converter_on);
      chk("cycle_cut", 32'h0, cycle_cut);
      pins_r.ss_arm_level <= 1'h0;
      set_flt(0, 1'h1);
      tick(3 * QC);
      set_flt(0, 1'h0);
      set_flt(1, 1'h1);
      tick(3 * QC);
      set_flt(1, 1'h0);
      tick(4);
      chk("converter_on", 32'h1, converter_on);
      pins_r.ss_arm_level <= 1'h1;
      recover();
      pins_r.soft_start_done_threshold <= 1'h0;
      want_on <= 1'h1;
      tick(SC + 15);
      chk("converter_on", 32'h0, converter_on);
      bus(1'h0, STA, st(6'h10, 4'h4, 2'h3), SM);
      recover();
      start_up();
      pins_r.vin_below_lockout <= 1'h1;
      pins_r.vin_above_release <= 1'h0;
      tick(8);
      chk("converter_on", 32'h0, converter_on);
      pins_r.vin_below_lockout <= 1'h0;
      tick(8);
      bus(1'h0, STA, 32'h800, 32'h800);
      pins_r.vin_above_release <= 1'h1;
      tick(12);
      chk("converter_on", 32'h1, converter_on);
      bus(1'h1, fault_sup_pkg::CTRL_ADDR, 32'h1, 32'h0);
      tick(2);
      chk("converter_on", 32'h0, converter_on);
      bus(1'h0, fault_sup_pkg::CTRL_ADDR, 32'h1, 32'h1);
      bus(1'h0, STA, st(6'h0, 4'h0, 2'h0), SM);
      bus(1'h1, fault_sup_pkg::CTRL_ADDR, 32'h0, 32'h0);
      tick(6);
      chk("converter_on", 32'h1, converter_on);
      end_of_test();
   end
endmodule // tb_top
